// ==== dsw_write_port.sv ====
/*
  dsw_write_port: receive-only three-wire serial write port holding the
  converter data register and the operating mode.
  assumes: frame select, serial clock and data come from an outside
  controller and are oversampled by clk_sys; no software registers.
  limitation: pin edges reach the outputs about three clocks late.
*/
// Behaviour
// - a sixteen-bit shift register collects one whole write word
// - data is sampled on the falling edges of the serial clock, up to sixteen per word
// - frame select is a level, active low, framing each word
// - frame select low enables shifting, one bit per falling edge
// - converter register updates only after the sixteenth edge
// - frame select rising before sixteenth edge aborts the write
// - word: two ignored, two mode, eight data, four ignored bits
// - mode bits pick normal or one of three power-downs at completion
// - abort clears the shift register, data and mode untouched
// - a new word needs a fresh falling edge of frame select
`default_nettype none
module dsw_write_port
  import dsw_pkg::*;
#(
  parameter int unsigned SYS_MHZ = dsw_pkg::DSW_SYS_MHZ
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdin,
  output logic [dsw_pkg::DSW_DATA_W-1:0] dac_data,
  output var dsw_pkg::dsw_mode_e op_mode,
  output logic load_pulse,
  output logic abort_pulse,
  output logic busy
);
  import dsw_pkg::*;

  // oversampling must see both serial clock phases at top speed: two
  // samples per half period, so a short half is never merged away
  localparam int unsigned SYS_MHZ_MIN = 4 * DSW_SCLK_MAX_HI_MHZ;
  localparam int unsigned PIN_N = 3;
  // frame select and serial clock idle high, data low
  localparam logic [PIN_N-1:0] PIN_IDLE = 3'b110;

  if (SYS_MHZ < SYS_MHZ_MIN) begin : g_bad_sys_mhz
    $error("dsw_write_port: SYS_MHZ too low for the serial clock");
  end
  // the counter must reach one whole word and both fields must fit
  if ((2 ** DSW_CNT_W) <= DSW_WORD_BITS) begin : g_bad_cnt_w
    $error("dsw_write_port: counter too narrow for one word");
  end
  if (DSW_CNT_FULL != DSW_CNT_W'(DSW_WORD_BITS)) begin : g_bad_cnt_end
    $error("dsw_write_port: counter end differs from word length");
  end
  if (DSW_DATA_MSB - DSW_DATA_LSB + 1 != DSW_DATA_W) begin : g_bad_data
    $error("dsw_write_port: data field width is wrong");
  end
  if (DSW_MODE_MSB - DSW_MODE_LSB + 1 != DSW_MODE_W) begin : g_bad_mode
    $error("dsw_write_port: mode field width is wrong");
  end
  if (DSW_MODE_MSB >= DSW_WORD_BITS) begin : g_bad_pos
    $error("dsw_write_port: mode field lies beyond the word");
  end
  if (DSW_MODE_LSB <= DSW_DATA_MSB) begin : g_bad_overlap
    $error("dsw_write_port: mode and data fields overlap");
  end

  logic [PIN_N-1:0] pins_s;
  logic sync_n_s;
  logic sclk_s;
  logic sdin_s;
  logic sync_n_d_reg;
  logic sclk_d_reg;
  dsw_state_e state_reg;
  dsw_state_e state_next;
  logic [DSW_WORD_BITS-1:0] shift_reg;
  logic [DSW_WORD_BITS-1:0] shift_next;
  logic [DSW_CNT_W-1:0] cnt_reg;
  logic [DSW_CNT_W-1:0] cnt_next;
  logic [DSW_DATA_W-1:0] data_reg;
  dsw_mode_e mode_reg;
  logic load_reg;
  logic abort_reg;
  logic sclk_fall;
  logic frame_fall;
  logic frame_rise;
  logic frame_on;
  logic frame_live;
  logic shift_take;
  logic word_done;
  logic early_abort;
  logic [DSW_WORD_BITS-1:0] word_full;
  logic [DSW_DATA_W-1:0] word_data;
  dsw_mode_e word_mode;

  // resets to the idle pin levels, so no false edge follows reset
  dsw_sync #(
    .WIDTH(PIN_N),
    .RST_VAL(PIN_IDLE)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in({sync_n, sclk, sdin}),
    .sync_out(pins_s)
  );

  assign sync_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdin_s = pins_s[0];

  // edge detection only looks at the synchronised copies
  assign sclk_fall = sclk_d_reg & ~sclk_s;
  assign frame_fall = sync_n_d_reg & ~sync_n_s;
  assign frame_rise = ~sync_n_d_reg & sync_n_s;
  assign frame_on = ~sync_n_s;
  // a fall seen together with the rising frame select still counts, so
  // frame select may rise right at the sixteenth edge
  assign frame_live = frame_on | frame_rise;
  assign shift_take = (state_reg == DSW_ST_SHIFT) && frame_live && sclk_fall;
  assign word_done = shift_take && (cnt_reg == DSW_CNT_FULL - 5'h01);
  assign early_abort = (state_reg == DSW_ST_SHIFT) && frame_rise &&
    !word_done;
  assign word_full = {shift_reg[DSW_WORD_BITS-2:0], sdin_s};
  // field decode of the word with its last bit already appended
  assign word_data = word_full[DSW_DATA_MSB:DSW_DATA_LSB];
  assign word_mode = dsw_mode_e'(word_full[DSW_MODE_MSB:DSW_MODE_LSB]);

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      DSW_ST_IDLE: begin
        if (frame_fall) begin
          state_next = DSW_ST_SHIFT;
          shift_next = '0;
          cnt_next = '0;
        end
      end
      DSW_ST_SHIFT: begin
        if (early_abort) begin
          state_next = DSW_ST_IDLE;
          shift_next = '0;
          cnt_next = '0;
        end else if (shift_take) begin
          shift_next = word_full;
          cnt_next = cnt_reg + 5'h01;
          if (word_done) begin
            state_next = DSW_ST_DONE;
          end
        end
      end
      DSW_ST_DONE: begin
        // clocks are ignored here; a completed word needs frame select
        // to go high before the next one can start
        if (sync_n_s) begin
          state_next = DSW_ST_IDLE;
        end
      end
      default: begin
        state_next = DSW_ST_IDLE;
        shift_next = '0;
        cnt_next = '0;
      end
    endcase
  end

  // edge history resets to the same idle levels as the synchroniser
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync_n_d_reg <= 1'b1;
      sclk_d_reg <= 1'b1;
    end else begin
      sync_n_d_reg <= sync_n_s;
      sclk_d_reg <= sclk_s;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= DSW_ST_IDLE;
      shift_reg <= '0;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
    end
  end

  // data and mode load together only at word completion, so a partial
  // or aborted word can never leave the two out of step
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_reg <= DSW_DATA_RST;
      mode_reg <= DSW_MODE_NORMAL;
    end else if (word_done) begin
      data_reg <= word_data;
      mode_reg <= word_mode;
    end
  end

  // one-cycle status pulses, registered so they line up with the data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      load_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      load_reg <= word_done;
      abort_reg <= early_abort;
    end
  end

  assign dac_data = data_reg;
  assign op_mode = mode_reg;
  assign load_pulse = load_reg;
  assign abort_pulse = abort_reg;
  // busy covers only the shifting state; a finished word that waits for
  // frame select to rise is no longer busy
  assign busy = (state_reg == DSW_ST_SHIFT);
endmodule : dsw_write_port
`default_nettype wire

// ==== dsw_pkg.sv ====
/*
  dsw_pkg: constants shared by the serial write port of the converter.
  assumes: system clock of 250 MHz samples the three serial pins.
*/
`default_nettype none
package dsw_pkg;
  localparam int unsigned DSW_WORD_BITS = 16;
  localparam int unsigned DSW_CNT_W = 5;
  localparam int unsigned DSW_DATA_W = 8;
  localparam int unsigned DSW_MODE_W = 2;
  // field positions, bit 15 is the first bit shifted in
  localparam int unsigned DSW_MODE_MSB = 13;
  localparam int unsigned DSW_MODE_LSB = 12;
  localparam int unsigned DSW_DATA_MSB = 11;
  localparam int unsigned DSW_DATA_LSB = 4;
  localparam logic [DSW_DATA_W-1:0] DSW_DATA_RST = 8'h00;
  localparam logic [DSW_CNT_W-1:0] DSW_CNT_FULL = 5'h10;
  // serial clock limits for the controller; the system clock must
  // sample each half period at least twice
  localparam int unsigned DSW_SCLK_MAX_HI_MHZ = 30;
  localparam int unsigned DSW_SCLK_MAX_LO_MHZ = 20;
  localparam int unsigned DSW_SYS_MHZ = 250;
  localparam int unsigned DSW_SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    DSW_MODE_NORMAL = 2'b00,
    DSW_MODE_PD_1K = 2'b01,
    DSW_MODE_PD_100K = 2'b10,
    DSW_MODE_PD_TRI = 2'b11
  } dsw_mode_e;
  typedef enum logic [1:0] {
    DSW_ST_IDLE = 2'b00,
    DSW_ST_SHIFT = 2'b01,
    DSW_ST_DONE = 2'b11
  } dsw_state_e;
endpackage : dsw_pkg
`default_nettype wire

// ==== dsw_sync.sv ====
/*
  dsw_sync: two-flop synchroniser for a bundle of asynchronous pins.
  assumes: inputs are stable levels slower than the sampling clock.
*/
`default_nettype none
module dsw_sync #(
  parameter int unsigned WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("dsw_sync: WIDTH must be at least 1");
  end

  // meta_reg feeds nothing but the second stage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : dsw_sync
`default_nettype wire

// ==== dsw_props.sv ====
/* dsw_props: port checks. assumes: bound to dsw_write_port. */
`default_nettype none
module dsw_props (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic [dsw_pkg::DSW_DATA_W-1:0] dac_data,
  input wire logic [dsw_pkg::DSW_MODE_W-1:0] op_mode,
  input wire logic load_pulse,
  input wire logic abort_pulse,
  input wire logic busy
);
  import dsw_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_ld1; load_pulse |=> !load_pulse; endproperty
  a_ld1: assert property (p_ld1) else $error("long load");
  property p_ab1; abort_pulse |=> !abort_pulse; endproperty
  a_ab1: assert property (p_ab1) else $error("long abort");
  property p_hold; !load_pulse |-> $stable(dac_data) && $stable(op_mode);
  endproperty
  a_hold: assert property (p_hold) else $error("stray update");
  property p_ldsrc; load_pulse |-> $past(busy) && !busy; endproperty
  a_ldsrc: assert property (p_ldsrc) else $error("load cause");
  property p_absrc;
    abort_pulse |-> $past(sync_n, 3) && !$past(sync_n, 4);
  endproperty
  a_absrc: assert property (p_absrc) else $error("abort cause");
  property p_idle; sync_n [*5] |-> !busy; endproperty
  a_idle: assert property (p_idle) else $error("busy unframed");
  property p_start;
    $rose(busy) |-> !$past(sync_n, 3) && $past(sync_n, 4);
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_end; $fell(busy) |-> load_pulse || abort_pulse; endproperty
  a_end: assert property (p_end) else $error("silent end");
  cover property (load_pulse && op_mode == DSW_MODE_PD_TRI);
  cover property (abort_pulse);
  cover property ($fell(busy) && load_pulse);
endmodule : dsw_props
bind dsw_write_port dsw_props dsw_props_i (.clk_sys(clk_sys),
  .reset_n(reset_n), .sync_n(sync_n), .sclk(sclk), .sdin(sdin),
  .dac_data(dac_data), .op_mode(op_mode), .load_pulse(load_pulse),
  .abort_pulse(abort_pulse), .busy(busy));
`default_nettype wire

// ==== dsw_master.sv ====
/* dsw_master: serial controller model. assumes: paced by clk_sys. */
`default_nettype none
module dsw_master (
  input wire logic clk_sys,
  output logic sync_n,
  output logic sclk,
  output logic sdin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sync_n = 1'b1;
    sclk = 1'b1;
    sdin = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // 32 ns halves stay below the lower clock limit
  task automatic send(input logic [15:0] w, input int n, input logic rel);
    sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdin = w[15 - i % 16];
      tick(8);
      sclk = 1'b0;
      tick(8);
      sclk = 1'b1;
    end
    tick(4);
    if (rel) sync_n = 1'b1;
    // a released line must not look like the last bit
    sdin = ~sdin;
    tick(12);
  endtask : send
endmodule : dsw_master
`default_nettype wire

// ==== dsw_write_port_tb.sv ====
/* dsw_write_port_tb: scenarios. assumes: dsw_master, dsw_props. */
`default_nettype none
module dsw_write_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dsw_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  wire logic sync_n, sclk, sdin, load_pulse, abort_pulse, busy;
  logic [7:0] dac_data;
  dsw_mode_e op_mode;
  int err_total = 0, compares = 0, n_load = 0, n_abort = 0;
  logic [7:0] d_exp = 8'h00;
  dsw_mode_e m_exp = DSW_MODE_NORMAL;
  always #2 clk_sys = ~clk_sys;
  dsw_master dsw_master_i (.clk_sys(clk_sys), .sync_n(sync_n),
    .sclk(sclk), .sdin(sdin));
  dsw_write_port dsw_write_port_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .sync_n(sync_n), .sclk(sclk), .sdin(sdin), .dac_data(dac_data),
    .op_mode(op_mode), .load_pulse(load_pulse),
    .abort_pulse(abort_pulse), .busy(busy));
  always @(posedge clk_sys) begin
    if (load_pulse === 1'b1) n_load <= n_load + 1;
    if (abort_pulse === 1'b1) n_abort <= n_abort + 1;
  end
  task automatic chk(input int l, input int a);
    compares++;
    if (dac_data !== d_exp || op_mode !== m_exp || n_load != l ||
        n_abort != a || busy !== 1'b0) begin
      err_total++;
      $display("MISMATCH t=%0t d %h m %b l %0d a %0d b %b", $time, dac_data,
        op_mode, n_load, n_abort, busy);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic t_modes;
    for (int k = 0; k < 4; k++) begin
      d_exp = 8'hff >> k;
      m_exp = dsw_mode_e'(k[1:0]);
      dsw_master_i.send({2'b11, m_exp, d_exp, 4'hf}, 16, 1'b1);
      chk(k + 1, 0);
    end
    $display("modes done");
  endtask : t_modes
  task automatic t_abort;
    dsw_master_i.send(16'h0000, 1, 1'b1);
    chk(4, 1);
    dsw_master_i.send(16'h0000, 15, 1'b1);
    chk(4, 2);
    d_exp = 8'h3c;
    m_exp = DSW_MODE_PD_1K;
    dsw_master_i.send(16'h13c0, 16, 1'b1);
    chk(5, 2);
    $display("abort done");
  endtask : t_abort
  task automatic t_reframe;
    d_exp = 8'hc3;
    m_exp = DSW_MODE_NORMAL;
    dsw_master_i.send(16'h0c30, 20, 1'b0);
    chk(6, 2);
    dsw_master_i.send(16'h3ff0, 16, 1'b1);
    chk(6, 2);
    $display("reframe done");
  endtask : t_reframe
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(0, 0);
    t_modes;
    t_abort;
    t_reframe;
    end_sim;
  end
  initial begin
    #60000;
    err_total++;
    $display("MISMATCH t=%0t watchdog", $time);
    end_sim;
  end
endmodule : dsw_write_port_tb
`default_nettype wire
